// >>> include/dsicfg_pkg.sv
package dsicfg_pkg;
    // Register byte offsets
    localparam logic [5:0] OFF_CONFIG = 6'h00;
    localparam logic [5:0] OFF_INPUT  = 6'h04;
    localparam logic [5:0] OFF_ALT    = 6'h08;
    localparam logic [5:0] OFF_LAST   = 6'h0C;
    localparam logic [5:0] OFF_DESER  = 6'h10;
    localparam logic [5:0] OFF_TIMED  = 6'h14;
    localparam logic [5:0] OFF_ATTR   = 6'h18;
    localparam logic [5:0] OFF_CTRL   = 6'h1C;
    localparam logic [5:0] OFF_MASK   = 6'h20;
    localparam logic [5:0] OFF_POL    = 6'h24;

    // dsi_config fields
    localparam int CF_MTO      = 0;
    localparam int CF_FSZ_EXT  = 1;
    localparam int CF_MULTI_TRANSFER_COUNT   = 2;   // 6 bits
    localparam int CF_TSB      = 8;
    localparam int CF_TXSRC    = 9;
    localparam int CF_TRIGGER_EDGE_POLARITY     = 10;
    localparam int CF_TRIG_EN  = 11;
    localparam int CF_CHG_EN   = 12;
    localparam int CF_HOLD     = 13;
    localparam int CF_ATTR     = 14;  // 3 bits
    localparam int CF_MSTOP    = 17;
    localparam int CF_PSTOP    = 18;
    localparam int CF_PE       = 19;
    localparam int CF_PP       = 20;
    localparam int CF_CS       = 21;  // 6 bits

    // timed_bus_config fields
    localparam int TB_CNT      = 0;   // 5 bits
    localparam int TB_MIDZ     = 5;
    localparam int TB_STARTZ   = 6;
    localparam int TB_CS2      = 7;   // 6 bits
    localparam int TB_GAP      = 13;  // 8 bits, inter-frame delay in ticks

    // ctrl/status fields
    localparam int CT_RUN      = 0;
    localparam int CT_MASTER   = 1;
    localparam int CT_RUNNING  = 2;
    localparam int CT_MATCH    = 8;
    localparam int CT_PERR     = 9;

    localparam int FSZ_W       = 4;
    localparam int NUM_CS      = 6;
    localparam logic [2:0]  SLAVE_ATTR   = 3'h1;
    localparam logic [6:0]  EXT_ADD      = 7'h10;
    localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
    localparam logic [31:0] RST_ATTR     = 32'h00FF_FFFF;
    localparam int unsigned SCK_HALF_DEF = 4;

    typedef enum logic [2:0] {
        DSI_IDLE = 3'b000,
        DSI_LEAD = 3'b001,
        DSI_LOW  = 3'b010,
        DSI_HIGH = 3'b011,
        DSI_GAP  = 3'b100
    } dsicfg_state_t;
endpackage

// >>> verilog/dsicfg_top.sv
// Contract
// [R1] Software leaves config alone while running
// [R2] Software avoids multi-transfer with timed bus
// [R3] Extension bit adds sixteen to frame size
// [R4] Multi-transfer clocks equal count plus one
// [R5] Timed bus: long frames, programmable gap
// [R6] Source select picks pin or alternate word
// [R7] Trigger polarity picks active trigger edge
// [R8] Trigger edges honoured only when enabled
// [R9] Changed word starts a frame when enabled
// [R10] Hold bit keeps chip selects after frame; the code ignores hold with the timed bus
// [R11] Attribute selector in master, one in slave
// [R12] Match flag stops frames when enabled
// [R13] Parity error stops frames when enabled
// [R14] Parity replaces last bit, checked on receive
// [R15] Chip-select bits assert their outputs
// [R16] Pin inputs captured every clock
// [R17] Alternate word applies at frame boundary
// [R18] Sent word copied at shift load
// [R19] Received word drives outputs, readable
// [R20] Timed bus frame carries count plus one bits
// [R21] Zero bits inserted at start and middle
// [R22] Second-part chip selects in timed bus
// [R23] Masked bit at polarity sets match flag
//
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ns
module dsicfg_top
    import dsicfg_pkg::*;
#(
    parameter int unsigned SCK_HALF = SCK_HALF_DEF
) (
    input  wire logic        clk_i,         // System clock
    input  wire logic        rst_i,         // Synchronous reset
    input  wire logic        cyc_i,         // Wishbone cycle
    input  wire logic        stb_i,         // Wishbone strobe
    input  wire logic        we_i,          // Wishbone write
    input  wire logic [5:0]  adr_i,         // Byte address
    input  wire logic [3:0]  sel_i,         // Byte enables
    input  wire logic [31:0] dat_i,         // Write data
    output logic      [31:0] dat_o,         // Read data
    output logic             ack_o,         // Wishbone ack
    input  wire logic [31:0] input_pin_word_i,  // Parallel inputs
    output logic      [31:0] output_pin_word_o, // Parallel outputs
    input  wire logic        hw_trigger_input_i, // Frame trigger pin
    output logic             sck_o,         // Serial clock, master
    input  wire logic        sck_i,         // Serial clock, slave
    input  wire logic        ss_n_i,        // Slave select, slave
    output logic             sout_o,        // Serial data out
    input  wire logic        sin_i,         // Serial data in
    output logic [NUM_CS-1:0] chip_select_n_o // Chip selects
);
    logic [31:0] config_ff, timed_ff, attr_ff, mask_ff, pol_ff;
    logic [31:0] alt_wr_ff, alt_word_ff, last_sent_ff, deser_ff;
    logic [31:0] pin_meta_ff, input_pin_word_ff;
    logic        run_ff, master_ff, running_ff;
    logic        match_ff, perr_ff;
    logic [2:0]  trig_sync_ff, sck_sync_ff, ss_sync_ff;
    logic        sin_meta_ff, sin_ff;
    dsicfg_state_t state_ff;
    logic [15:0] tick_cnt_ff;
    logic [7:0]  gap_cnt_ff;
    logic [6:0]  pos_ff, dcnt_ff, tot_ff, dlen_ff, mid_ff, split_ff;
    logic [31:0] tx_sh_ff, rx_sh_ff;
    logic        txpar_ff, rxpar_ff, cs_hold_ff;
    logic        ack_ff;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] low_mask(input logic [6:0] n);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 32; i++) begin
            if (7'(i) < n) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // Config decode
    logic       timed_serial_bus, tx_src, trigger_edge_polarity, trig_en, chg_en, hold;
    logic       mstop, pstop, pe, pp, mto;
    logic [2:0] attr_sel;
    logic [FSZ_W-1:0] frame_size_field;
    logic [6:0] flen, mto_clks, tb_bits, zeros, tot_calc, mid_calc;
    logic [NUM_CS-1:0] cs1, cs2;
    logic       wr_ok;
    assign timed_serial_bus      = config_ff[CF_TSB];
    assign tx_src   = config_ff[CF_TXSRC];
    assign trigger_edge_polarity     = config_ff[CF_TRIGGER_EDGE_POLARITY];
    assign trig_en  = config_ff[CF_TRIG_EN];
    assign chg_en   = config_ff[CF_CHG_EN];
    assign hold     = config_ff[CF_HOLD];
    assign mstop    = config_ff[CF_MSTOP];
    assign pstop    = config_ff[CF_PSTOP];
    assign pe       = config_ff[CF_PE];
    assign pp       = config_ff[CF_PP];
    assign mto      = config_ff[CF_MTO];
    assign cs1      = config_ff[CF_CS +: NUM_CS];
    assign cs2      = timed_ff[TB_CS2 +: NUM_CS];
    assign attr_sel = master_ff ? config_ff[CF_ATTR +: 3] : SLAVE_ATTR; // [R11]
    assign frame_size_field     = attr_ff[attr_sel*FSZ_W +: FSZ_W];
    assign flen     = 7'(frame_size_field) + 7'h01
                    + (config_ff[CF_FSZ_EXT] ? EXT_ADD : 7'h00); // [R3]
    assign mto_clks = 7'(config_ff[CF_MULTI_TRANSFER_COUNT +: 6]) + 7'h01; // [R4]
    assign tb_bits  = 7'(timed_ff[TB_CNT +: 5]) + 7'h01; // [R20]
    assign zeros    = 7'(timed_ff[TB_STARTZ]) + 7'(timed_ff[TB_MIDZ]);
    // Timed bus ignores the multi-transfer count, and timed_ff is only
    // consulted when the timed bus is on
    assign tot_calc = timed_serial_bus ? tb_bits + zeros                // [R5] [R21]
                    : (mto ? mto_clks : flen);             // [R4]
    assign mid_calc = 7'(timed_ff[TB_STARTZ]) + 7'(frame_size_field) + 7'h01; // [R21]

    // Serialization word
    logic [31:0] ser_word;
    assign ser_word = tx_src ? alt_word_ff : input_pin_word_ff; // [R6]

    // Pin synchronisers
    always_ff @(posedge clk_i) begin
        pin_meta_ff       <= input_pin_word_i;
        input_pin_word_ff <= pin_meta_ff;                  // [R16]
        trig_sync_ff      <= {trig_sync_ff[1:0], hw_trigger_input_i};
        sck_sync_ff       <= {sck_sync_ff[1:0], sck_i};
        ss_sync_ff        <= {ss_sync_ff[1:0], ss_n_i};
        sin_meta_ff       <= sin_i;
        sin_ff            <= sin_meta_ff;
    end

    logic trig_rise, trig_fall, trig_hit, chg_hit, sck_rise, sck_fall;
    logic ss_fall, ss_high;
    assign trig_rise = trig_sync_ff[1] & ~trig_sync_ff[2];
    assign trig_fall = ~trig_sync_ff[1] & trig_sync_ff[2];
    assign trig_hit  = trig_en & (trigger_edge_polarity ? trig_rise : trig_fall); // [R7] [R8]
    assign chg_hit   = chg_en & (ser_word != last_sent_ff);     // [R9]
    assign sck_rise  = sck_sync_ff[1] & ~sck_sync_ff[2];
    assign sck_fall  = ~sck_sync_ff[1] & sck_sync_ff[2];
    assign ss_fall   = ~ss_sync_ff[1] & ss_sync_ff[2];
    assign ss_high   = ss_sync_ff[1];

    // Half-period tick for the master serial clock
    logic tick;
    assign tick = (tick_cnt_ff == 16'(SCK_HALF - 1));
    always_ff @(posedge clk_i) begin
        if (rst_i || state_ff == DSI_IDLE || tick) begin
            tick_cnt_ff <= 16'h0000;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 16'h0001;
        end
    end

    // Bit classification for the current position
    logic zero_bit, par_bit, data_bit, out_bit, last_pos, second_part;
    logic stop_req, start_req, smp_ev, adv_ev;
    assign zero_bit = timed_serial_bus && ((timed_ff[TB_STARTZ] && pos_ff == 7'h00)
                    || (timed_ff[TB_MIDZ] && pos_ff == mid_ff)); // [R21]
    assign data_bit = ~zero_bit;
    assign par_bit  = pe && (dcnt_ff == dlen_ff - 7'h01);
    // Parity bit makes the count of ones even (pp=0) or odd
    assign out_bit  = zero_bit ? 1'b0
                    : (par_bit ? (txpar_ff ^ pp) : tx_sh_ff[31]); // [R14]
    assign last_pos = (pos_ff == tot_ff - 7'h01);
    assign second_part = timed_serial_bus && (dcnt_ff >= split_ff);      // [R22]
    assign stop_req = (mstop && match_ff)                   // [R12]
                    || (pstop && perr_ff);                  // [R13]
    assign start_req = running_ff && !stop_req
                     && (master_ff ? (trig_hit || chg_hit) : ss_fall);
    assign smp_ev = master_ff ? tick : sck_rise;
    assign adv_ev = master_ff ? tick : sck_fall;

    logic frame_done;
    assign frame_done = (state_ff == DSI_HIGH) && adv_ev && last_pos;

    // Frame sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= DSI_IDLE;
        end else begin
            case (state_ff)
                DSI_IDLE: begin
                    if (start_req) begin
                        state_ff <= master_ff ? DSI_LEAD : DSI_LOW;
                    end
                end
                DSI_LEAD: begin
                    if (tick) begin
                        state_ff <= DSI_LOW;
                    end
                end
                DSI_LOW: begin
                    if (!master_ff && ss_high) begin
                        state_ff <= DSI_IDLE;
                    end else if (smp_ev) begin
                        state_ff <= DSI_HIGH;
                    end
                end
                DSI_HIGH: begin
                    if (!master_ff && ss_high) begin
                        state_ff <= DSI_IDLE;
                    end else if (adv_ev) begin
                        state_ff <= last_pos ? DSI_GAP : DSI_LOW;
                    end
                end
                DSI_GAP: begin
                    if (!master_ff || (tick && gap_cnt_ff == 8'h00)) begin
                        state_ff <= DSI_IDLE;
                    end
                end
                default: state_ff <= DSI_IDLE;
            endcase
        end
    end

    // Inter-frame delay, programmable only with the timed bus
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gap_cnt_ff <= 8'h00;
        end else if (frame_done) begin
            gap_cnt_ff <= timed_serial_bus ? timed_ff[TB_GAP +: 8] : 8'h00; // [R5]
        end else if (state_ff == DSI_GAP && tick && gap_cnt_ff != 8'h00) begin
            gap_cnt_ff <= gap_cnt_ff - 8'h01;
        end
    end

    // Shift datapath
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pos_ff   <= 7'h00;
            dcnt_ff  <= 7'h00;
            tot_ff   <= 7'h01;
            dlen_ff  <= 7'h01;
            mid_ff   <= 7'h00;
            split_ff <= 7'h00;
            tx_sh_ff <= RST_ZERO;
            rx_sh_ff <= RST_ZERO;
            txpar_ff <= 1'b0;
            rxpar_ff <= 1'b0;
        end else if (state_ff == DSI_IDLE && start_req) begin
            pos_ff   <= 7'h00;
            dcnt_ff  <= 7'h00;
            tot_ff   <= tot_calc;
            dlen_ff  <= timed_serial_bus ? tb_bits : flen;
            mid_ff   <= mid_calc;
            split_ff <= 7'(frame_size_field) + 7'h01;
            // Left-align so the frame's top bit leaves first
            tx_sh_ff <= ser_word << (7'h20 - (timed_serial_bus ? tb_bits : flen));
            rx_sh_ff <= RST_ZERO;
            txpar_ff <= 1'b0;
            rxpar_ff <= 1'b0;
        end else if (state_ff == DSI_LOW && smp_ev && data_bit) begin
            rx_sh_ff <= {rx_sh_ff[30:0], sin_ff};
            if (dcnt_ff < dlen_ff) begin
                rxpar_ff <= rxpar_ff ^ sin_ff;             // [R14]
            end
        end else if (state_ff == DSI_HIGH && adv_ev) begin
            pos_ff <= pos_ff + 7'h01;
            if (data_bit) begin
                tx_sh_ff <= {tx_sh_ff[30:0], 1'b0};
                txpar_ff <= txpar_ff ^ tx_sh_ff[31];
                dcnt_ff  <= dcnt_ff + 7'h01;
            end
        end
    end

    // Frame results: received word, parity check, match detection
    logic [31:0] rx_word;
    logic        perr_ev, match_ev;
    assign rx_word  = rx_sh_ff & low_mask(dlen_ff);
    assign perr_ev  = frame_done && pe && (rxpar_ff ^ pp);        // [R14]
    assign match_ev = frame_done
                    && |(mask_ff & ~(rx_word ^ pol_ff));          // [R23]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            deser_ff <= RST_ZERO;
        end else if (frame_done) begin
            deser_ff <= rx_word;                           // [R19]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_sent_ff <= RST_ZERO;
        end else if (state_ff == DSI_IDLE && start_req) begin
            last_sent_ff <= ser_word;                      // [R18]
        end
    end

    // Alternate word only reaches the serializer between frames
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alt_word_ff <= RST_ZERO;
        end else if (state_ff == DSI_IDLE) begin
            alt_word_ff <= alt_wr_ff;                      // [R17]
        end
    end

    // Running state changes only outside a frame
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            running_ff <= 1'b0;
        end else if (state_ff == DSI_IDLE) begin
            running_ff <= run_ff;
        end
    end

    // Serial outputs and chip selects
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sck_o           <= 1'b0;
            sout_o          <= 1'b0;
            chip_select_n_o <= {NUM_CS{1'b1}};
            cs_hold_ff      <= 1'b0;
        end else begin
            sck_o  <= master_ff && state_ff == DSI_HIGH;
            sout_o <= (state_ff == DSI_LOW || state_ff == DSI_HIGH)
                    ? out_bit : 1'b0;
            if (frame_done) begin
                cs_hold_ff <= master_ff && hold && !timed_serial_bus;   // [R10]
            end else if (state_ff == DSI_IDLE && !hold) begin
                cs_hold_ff <= 1'b0;
            end
            if (!master_ff) begin
                chip_select_n_o <= {NUM_CS{1'b1}};
            end else if (state_ff == DSI_LEAD || state_ff == DSI_LOW
                         || state_ff == DSI_HIGH) begin
                chip_select_n_o <= second_part ? ~cs2 : ~cs1; // [R15] [R22]
            end else if (cs_hold_ff) begin
                chip_select_n_o <= ~cs1;                   // [R10]
            end else begin
                chip_select_n_o <= {NUM_CS{1'b1}};
            end
        end
    end

    assign output_pin_word_o = deser_ff;                   // [R19]

    // Wishbone slave: ack one cycle after the request, write at ack edge
    assign wr_ok = cyc_i && stb_i && we_i && ack_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_o  <= RST_ZERO;
        end else begin
            ack_ff <= cyc_i && stb_i && !ack_ff;
            case (adr_i)
                OFF_CONFIG: dat_o <= config_ff;
                OFF_INPUT:  dat_o <= input_pin_word_ff;
                OFF_ALT:    dat_o <= alt_wr_ff;
                OFF_LAST:   dat_o <= last_sent_ff;
                OFF_DESER:  dat_o <= deser_ff;
                OFF_TIMED:  dat_o <= timed_ff;
                OFF_ATTR:   dat_o <= attr_ff;
                OFF_CTRL:   dat_o <= {22'h0, perr_ff, match_ff, 5'h00,
                                      running_ff, master_ff, run_ff};
                OFF_MASK:   dat_o <= mask_ff;
                OFF_POL:    dat_o <= pol_ff;
                default:    dat_o <= RST_ZERO;
            endcase
        end
    end
    assign ack_o = ack_ff;

    // Software-written registers; config must be stable while running
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            config_ff <= RST_ZERO;
            timed_ff  <= RST_ZERO;
            alt_wr_ff <= RST_ZERO;
            attr_ff   <= RST_ATTR;
            mask_ff   <= RST_ZERO;
            pol_ff    <= RST_ZERO;
            run_ff    <= 1'b0;
            master_ff <= 1'b1;
        end else if (wr_ok) begin
            case (adr_i)
                OFF_CONFIG: config_ff <= merge(config_ff, dat_i, sel_i);
                OFF_TIMED:  timed_ff  <= merge(timed_ff, dat_i, sel_i);
                OFF_ALT:    alt_wr_ff <= merge(alt_wr_ff, dat_i, sel_i);
                OFF_ATTR:   attr_ff   <= merge(attr_ff, dat_i, sel_i);
                OFF_MASK:   mask_ff   <= merge(mask_ff, dat_i, sel_i);
                OFF_POL:    pol_ff    <= merge(pol_ff, dat_i, sel_i);
                OFF_CTRL: begin
                    if (sel_i[0]) begin
                        run_ff    <= dat_i[CT_RUN];
                        master_ff <= dat_i[CT_MASTER];
                    end
                end
                default: ;
            endcase
        end
    end

    // Sticky flags: a new event wins over a write-one clear
    logic clr_match, clr_perr;
    assign clr_match = wr_ok && adr_i == OFF_CTRL && sel_i[1]
                     && dat_i[CT_MATCH];
    assign clr_perr  = wr_ok && adr_i == OFF_CTRL && sel_i[1]
                     && dat_i[CT_PERR];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            match_ff <= 1'b0;
            perr_ff  <= 1'b0;
        end else begin
            match_ff <= match_ev || (match_ff && !clr_match);  // [R23]
            perr_ff  <= perr_ev || (perr_ff && !clr_perr);     // [R14]
        end
    end
endmodule

// >>> sim/dsicfg_monitor.sv
`timescale 1ns/1ns
module dsicfg_monitor
    import dsicfg_pkg::*;
#(
    parameter int unsigned SCK_HALF = SCK_HALF_DEF
) (
    input wire logic              clk_i,             // Clock
    input wire logic              rst_i,             // Reset
    input wire logic              cyc_i,             // Bus cycle
    input wire logic              stb_i,             // Bus strobe
    input wire logic              we_i,              // Bus write
    input wire logic [5:0]        adr_i,             // Bus address
    input wire logic [31:0]       dat_o,             // Read data
    input wire logic              ack_o,             // Bus ack
    input wire logic [31:0]       output_pin_word_o, // Parallel outputs
    input wire logic              sck_o,             // Serial clock
    input wire logic [NUM_CS-1:0] chip_select_n_o    // Chip selects
);
    logic [7:0] hi_cnt_ff; // Length of the current sck high phase

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hi_cnt_ff <= 8'h00;
        end else begin
            hi_cnt_ff <= sck_o ? hi_cnt_ff + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_resp_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("bus request not answered");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (ack_o |-> $past(stb_i))
        else $error("ack without request");
    reset_idle_a: assert property ($fell(rst_i) |-> &chip_select_n_o
                                  && !sck_o && !ack_o)
        else $error("outputs not idle after reset");
    sck_idle_a: assert property (&chip_select_n_o |-> !sck_o)
        else $error("serial clock runs without a chip select");
    sck_half_a: assert property ($fell(sck_o)
        |-> hi_cnt_ff == SCK_HALF)
        else $error("serial clock high phase has wrong length");
    cs_steady_a: assert property (sck_o |-> $stable(chip_select_n_o))
        else $error("chip selects move while sck high");
    deser_read_a: assert property (ack_o && !we_i
        && adr_i == OFF_DESER |-> dat_o == $past(output_pin_word_o))
        else $error("received word read differs from outputs");
    // The word lands with the last clock high phase, which ends one
    // cycle later
    out_frame_a: assert property (!$stable(output_pin_word_o)
        |=> !sck_o)
        else $error("parallel outputs change mid bit");

    cover property ($fell(chip_select_n_o[0]));
    cover property (!$stable(output_pin_word_o));
    cover property (ack_o && !we_i && adr_i == OFF_DESER);
endmodule

bind dsicfg_top dsicfg_monitor #(.SCK_HALF(SCK_HALF)) u_mon (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
    .output_pin_word_o(output_pin_word_o), .sck_o(sck_o),
    .chip_select_n_o(chip_select_n_o));

// >>> sim/dsicfg_peer.sv
`timescale 1ns/1ns
module dsicfg_peer #(
    parameter logic [7:0] REPLY = 8'h3C
) (
    input  wire logic sck_i,  // Serial clock from master
    input  wire logic cs_n_i, // Chip select, active low
    input  wire logic sdi_i,  // Data from master
    output logic      sdo_o,  // Data to master
    output logic [7:0] rx_o   // Last bits received
);
    logic [7:0] sh;

    initial begin
        sdo_o = 1'b0;
        rx_o  = 8'h00;
    end
    always @(negedge cs_n_i) begin
        sh    = REPLY;
        sdo_o = REPLY[7];
        rx_o  = 8'h00;
    end
    always @(posedge sck_i) if (!cs_n_i) rx_o = {rx_o[6:0], sdi_i};
    always @(negedge sck_i) if (!cs_n_i) begin
        sh    = {sh[6:0], 1'b0};
        sdo_o = sh[7];
    end
    // Released line: show the inverse so a stale value never matches
    always @(posedge cs_n_i) sdo_o = ~sdo_o;
endmodule

// >>> sim/dsicfg_top_test.sv
`timescale 1ns/1ns
module dsicfg_top_test;
    import dsicfg_pkg::*;
    logic clk_i, rst_i, cyc, stb, we, trig, sck, ss_n, tsin, slv;
    logic [5:0]  adr;
    logic [31:0] dat, dat_o, rv, opw;
    logic ack_o, sck_o, sout_o, psdo;
    logic [5:0] cs_n;
    logic [7:0] prx;
    int n_fail, total_checks;
    bit seen;

    dsicfg_top #(.SCK_HALF(4)) uut (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF),
        .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
        .input_pin_word_i(32'h1234_ABCD), .output_pin_word_o(opw),
        .hw_trigger_input_i(trig), .sck_o(sck_o), .sck_i(sck),
        .ss_n_i(ss_n), .sout_o(sout_o), .sin_i(slv ? tsin : psdo),
        .chip_select_n_o(cs_n));
    dsicfg_peer peer (.sck_i(sck_o), .cs_n_i(cs_n[0]), .sdi_i(sout_o),
        .sdo_o(psdo), .rx_o(prx));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [5:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) n_fail++;
        rv = dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    // Waits for a frame on select 0; the peer answers with 8'h3C
    task automatic frame();
        int n;
        seen = 0;
        for (n = 0; n < 60 && cs_n[0] !== 1'b0; n++) @(posedge clk_i);
        if (cs_n[0] === 1'b0) begin
            seen = 1;
            @(posedge clk_i);
            chk({26'h0, cs_n}, 32'h0000_003E);
            for (n = 0; n < 300 && cs_n[0] !== 1'b1; n++) @(posedge clk_i);
            repeat (4) @(posedge clk_i);
        end
    endtask

    task automatic t_regs();
        wb(0, OFF_CONFIG, 0); chk(rv, 32'h0);
        wb(0, OFF_CTRL, 0);   chk(rv & 32'h7, 32'h2);
        wb(0, 6'h3C, 0);      chk(rv, 32'h0);
        wb(1, OFF_INPUT, 32'hFFFF_FFFF);
        wb(0, OFF_INPUT, 0);  chk(rv, 32'h1234_ABCD);
        $display("test regs done");
    endtask

    task automatic t_alt();
        wb(1, OFF_ATTR, 32'h0000_0077);
        wb(1, OFF_CONFIG, 32'h0020_0E00);
        wb(1, OFF_ALT, 32'h0000_00A5);
        wb(1, OFF_CTRL, 32'h3);
        trig <= 1'b1;
        frame();
        chk(seen, 1);
        chk(prx, 8'hA5);
        wb(0, OFF_LAST, 0);  chk(rv, 32'h0000_00A5);
        wb(0, OFF_DESER, 0); chk(rv, 32'h0000_003C);
        chk(opw, 32'h0000_003C);
        $display("test alternate frame done");
    endtask

    task automatic t_gate();
        wb(1, OFF_CTRL, 32'h2);
        wb(1, OFF_CONFIG, 32'h0020_0200);
        wb(1, OFF_ALT, 32'h0000_005A);
        wb(1, OFF_CTRL, 32'h3);
        trig <= 1'b0;
        frame(); chk(seen, 0);
        wb(1, OFF_CTRL, 32'h2);
        wb(1, OFF_CONFIG, 32'h0020_0A00);
        wb(1, OFF_CTRL, 32'h3);
        trig <= 1'b1;
        frame(); chk(seen, 0);
        trig <= 1'b0;
        frame(); chk(seen, 1);
        chk(prx, 8'h5A);
        wb(0, OFF_LAST, 0); chk(rv, 32'h0000_005A);
        $display("test trigger gating done");
    endtask

    task automatic t_slave();
        logic [7:0] w;
        w = 8'h96;
        wb(1, OFF_CTRL, 32'h0);
        wb(1, OFF_ATTR, 32'h0000_007F);
        wb(1, OFF_CTRL, 32'h1);
        slv <= 1'b1; ss_n <= 1'b0;
        repeat (4) @(posedge clk_i);
        for (int i = 7; i >= 0; i--) begin
            tsin <= w[i];
            repeat (4) @(posedge clk_i);
            sck <= 1'b1;
            repeat (4) @(posedge clk_i);
            sck <= 1'b0;
        end
        repeat (8) @(posedge clk_i);
        ss_n <= 1'b1; tsin <= ~w[0];
        repeat (10) @(posedge clk_i);
        wb(0, OFF_DESER, 0); chk(rv, 32'h0000_0096);
        chk(opw, 32'h0000_0096);
        $display("test slave frame done");
    endtask

    // Pin word with even parity: 1100110 then a 0 parity bit
    task automatic t_chg();
        slv <= 1'b0;
        wb(1, OFF_CTRL, 32'h2);
        wb(1, OFF_ATTR, 32'h0000_0077);
        wb(1, OFF_CONFIG, 32'h0028_1000);
        wb(1, OFF_CTRL, 32'h3);
        frame(); chk(seen, 1);
        chk(prx, 8'hCC);
        frame(); chk(seen, 0);
        wb(0, OFF_LAST, 0); chk(rv, 32'h1234_ABCD);
        wb(0, OFF_CTRL, 0); chk(rv & 32'h300, 32'h0);
        $display("test change start done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        rst_i = 1'b1; cyc = 0; stb = 0; we = 0; adr = 0; dat = 0;
        trig = 0; sck = 0; ss_n = 1; tsin = 0; slv = 0;
        n_fail = 0; total_checks = 0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_alt();
        t_gate();
        t_slave();
        t_chg();
        tally_and_finish();
    end

    // Whole run needs about 600 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        tally_and_finish();
    end
endmodule
